// >>> rtl/scpi_pkg.sv
package scpi_pkg;

	// ----------------------------------------------------------------
	// character codes and limits
	// ----------------------------------------------------------------
	localparam logic [7:0] CH_NL = 8'h0a;
	localparam logic [7:0] WS_LO_MAX = 8'h09;
	localparam logic [7:0] WS_HI_MIN = 8'h0b;
	localparam logic [7:0] WS_HI_MAX = 8'h20;
	localparam logic [7:0] CH_STAR = 8'h2a;
	localparam logic [7:0] CH_COMMA = 8'h2c;
	localparam logic [7:0] CH_COLON = 8'h3a;
	localparam logic [7:0] CH_SEMI = 8'h3b;
	localparam logic [7:0] CH_QUERY = 8'h3f;
	localparam logic [7:0] CH_ZERO = 8'h30;
	localparam logic [7:0] CH_NINE = 8'h39;
	localparam logic [7:0] CH_A_UP = 8'h41;
	localparam logic [7:0] CH_Z_UP = 8'h5a;
	localparam logic [7:0] CH_A_LO = 8'h61;
	localparam logic [7:0] CH_Z_LO = 8'h7a;
	localparam logic [7:0] CASE_BIT = 8'h20;
	localparam logic [7:0] SUFFIX_DEFAULT = 8'h01;
	localparam logic [7:0] SUFFIX_LIMIT = 8'h19;
	localparam logic [3:0] KW_CHARS = 4'hc;
	localparam logic [3:0] KW_OVER = 4'hd;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef logic [95:0] kw_text_t;
	typedef logic [4:0] node_t;
	localparam node_t NODE_ROOT = 5'h00;
	localparam node_t NODE_COMMON = 5'h1f;
	typedef enum logic [1:0] {PAR_RAW, PAR_MIN, PAR_MAX, PAR_DEF} par_kind_e;

	typedef struct packed {
		kw_text_t text;
		logic [3:0] slen;
		logic [3:0] llen;
		node_t parent;
		logic opt;
	} kw_s;

	typedef struct packed {
		node_t func;
		logic query;
		logic common;
		logic [7:0] suffix;
	} cmd_s;

	typedef struct packed {
		logic [7:0] data;
		logic [3:0] idx;
		par_kind_e kind;
	} par_s;

	// ----------------------------------------------------------------
	// keyword tree, node id is index plus one; text right aligned
	// ----------------------------------------------------------------
	localparam int KW_N = 23;
	localparam kw_s KW_TABLE [KW_N] = '{
		'{96'("SENSE"), 4'h4, 4'h5, 5'h00, 1'b1},
		'{96'("FREQUENCY"), 4'h4, 4'h9, 5'h01, 1'b0},
		'{96'("CENTER"), 4'h4, 4'h6, 5'h02, 1'b0},
		'{96'("START"), 4'h4, 4'h5, 5'h02, 1'b0},
		'{96'("STOP"), 4'h4, 4'h4, 5'h02, 1'b0},
		'{96'("SPAN"), 4'h4, 4'h4, 5'h02, 1'b0},
		'{96'("LINK"), 4'h4, 4'h4, 5'h06, 1'b0},
		'{96'("BANDWIDTH"), 4'h4, 4'h9, 5'h01, 1'b0},
		'{96'("RESOLUTION"), 4'h3, 4'ha, 5'h08, 1'b1},
		'{96'("AUTO"), 4'h4, 4'h4, 5'h09, 1'b0},
		'{96'("INPUT"), 4'h3, 4'h5, 5'h00, 1'b0},
		'{96'("ATTENUATION"), 4'h3, 4'hb, 5'h0b, 1'b0},
		'{96'("COUPLING"), 4'h4, 4'h8, 5'h0b, 1'b0},
		'{96'("SOURCE"), 4'h4, 4'h6, 5'h00, 1'b0},
		'{96'("FM"), 4'h2, 4'h2, 5'h0e, 1'b0},
		'{96'("POLARITY"), 4'h3, 4'h8, 5'h0f, 1'b0},
		'{96'("EXTERNAL"), 4'h3, 4'h8, 5'h0f, 1'b0},
		'{96'("POLARITY"), 4'h3, 4'h8, 5'h11, 1'b0},
		'{96'("RST"), 4'h3, 4'h3, 5'h1f, 1'b0},
		'{96'("ESE"), 4'h3, 4'h3, 5'h1f, 1'b0},
		'{96'("ESR"), 4'h3, 4'h3, 5'h1f, 1'b0},
		'{96'("CLS"), 4'h3, 4'h3, 5'h1f, 1'b0},
		'{96'("IDN"), 4'h3, 4'h3, 5'h1f, 1'b0}
	};

	// symbolic parameter words
	localparam kw_text_t SPC_MIN = 96'("MINIMUM");
	localparam kw_text_t SPC_MAX = 96'("MAXIMUM");
	localparam kw_text_t SPC_DEF = 96'("DEFAULT");
	localparam logic [3:0] SPC_SLEN = 4'h3;
	localparam logic [3:0] SPC_LLEN = 4'h7;

	// short form is the leading slen characters of the long form
	function automatic logic kw_hit(kw_text_t kb, logic [3:0] kl, kw_text_t name,
			logic [3:0] slen, logic [3:0] llen);
		logic [6:0] sh;
		sh = {llen - slen, 3'b000};
		return (kl == llen && kb == name) || (kl == slen && kb == (name >> sh));
	endfunction

	// parent is an optional keyword that hangs directly below cur
	function automatic logic opt_hop(node_t p, node_t cur);
		if (p == NODE_ROOT || p == NODE_COMMON) begin
			return 1'b0;
		end
		return KW_TABLE[int'(p) - 1].opt && KW_TABLE[int'(p) - 1].parent == cur;
	endfunction

endpackage

// >>> rtl/scpi_header_parser.sv
`timescale 1ns/10ps
// Contract
// - message bytes count only while attention is low
// - a finished query requests response output; settings produce none
// - responses are requested only after a received query
// - codes 0 to 9 and 11 to 32 are white space after header
// - question mark directly after header marks a query
// - asterisk start decodes a common command with any parameters
// - a single root keyword selects a whole subsystem
// - keywords decode by their position in the path
// - optional keywords may be present or left out
// - only short or full long keyword forms match
// - letter case is ignored when matching
// - parameters split at commas
// - min, max and default words become markers in queries
// - line ends at newline or end-or-identify
// - semicolon separates commands; following colon returns to root
// - no colon continues at current path; new line restarts root
// - missing numeric suffix means suffix one
module scpi_header_parser
	import scpi_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic byte_valid,
	input wire logic [7:0] byte_data,
	input wire logic atn,
	input wire logic eoi,
	output logic byte_ready,
	input wire logic resp_ack,
	output logic resp_req,
	output logic cmd_valid,
	output cmd_s cmd,
	output logic par_valid,
	output logic par_end,
	output par_s par,
	output logic done_valid,
	output logic cmd_err
);

	typedef enum logic [2:0] {ST_START, ST_HDR, ST_AFTQ, ST_GAP, ST_PAR, ST_SKIP} state_e;

	state_e st_r, st_nxt;
	node_t cur_r, cur_nxt, base_r, base_nxt, look_cur, hit_id;
	kw_text_t kb_r, kb_nxt, kb_v;
	logic [3:0] kl_r, kl_nxt, kl_v, pidx_r, pidx_nxt;
	logic [7:0] suf_r, suf_nxt, suf_v, up;
	logic sufon_r, sufon_nxt, sufon_v, query_r, query_nxt, common_r, common_nxt;
	logic resp_r, resp_nxt, cmdv_r, cmdv_nxt, parv_r, parv_nxt, pend_r, pend_nxt;
	logic done_r, done_nxt, err_r, err_nxt, name_bad;
	cmd_s cmd_r, cmd_nxt;
	par_s par_r, par_nxt;
	logic take, ws, nl, letter, digit, endl, delim, any_hit;
	logic [KW_N-1:0] hit;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	// ----------------------------------------------------------------
	// byte classification
	// ----------------------------------------------------------------
	// attention gating
	assign take = byte_valid && byte_ready && !atn;
	assign ws = byte_data <= WS_LO_MAX || (byte_data >= WS_HI_MIN && byte_data <= WS_HI_MAX);
	assign nl = byte_data == CH_NL;
	assign endl = nl || eoi;
	assign letter = (byte_data >= CH_A_UP && byte_data <= CH_Z_UP) ||
		(byte_data >= CH_A_LO && byte_data <= CH_Z_LO);
	assign digit = byte_data >= CH_ZERO && byte_data <= CH_NINE;
	// end-or-identify rides on a data byte, so it never makes that byte a delimiter
	assign delim = ws || nl || byte_data == CH_COLON || byte_data == CH_SEMI ||
		byte_data == CH_QUERY || byte_data == CH_COMMA;
	assign up = (byte_data >= CH_A_LO && byte_data <= CH_Z_LO) ? (byte_data & ~CASE_BIT) :
		byte_data;
	// stalls while a response is owed, so no new line overtakes it
	assign byte_ready = !resp_r;

	// ----------------------------------------------------------------
	// append stage: buffer as it stands with this byte included
	// ----------------------------------------------------------------
	always_comb begin
		kb_v = kb_r;
		kl_v = kl_r;
		suf_v = suf_r;
		sufon_v = sufon_r;
		name_bad = 1'b0;
		if (st_r == ST_START || st_r == ST_HDR) begin
			if (letter) begin
				name_bad = sufon_r;
				kb_v = {kb_r[87:0], up};
				kl_v = (kl_r >= KW_CHARS) ? KW_OVER : 4'(kl_r + 4'h1);
			end else if (digit) begin
				// a suffix needs letters before it and stays small
				name_bad = kl_r == 4'h0 || suf_r > SUFFIX_LIMIT;
				sufon_v = 1'b1;
				suf_v = 8'(suf_r * 8'h0a + (byte_data - CH_ZERO));
			end
		end else if ((st_r == ST_GAP || st_r == ST_PAR) && !delim) begin
			// overlong text saturates the length and never matches a word
			kb_v = {kb_r[87:0], up};
			kl_v = (kl_r >= KW_CHARS) ? KW_OVER : 4'(kl_r + 4'h1);
		end
	end

	// ----------------------------------------------------------------
	// keyword lookup at the current path node
	// ----------------------------------------------------------------
	assign look_cur = (st_r == ST_START) ? base_r : cur_r;
	for (genvar i = 0; i < KW_N; i++) begin : g_kw
		assign hit[i] = kw_hit(kb_v, kl_v, KW_TABLE[i].text, KW_TABLE[i].slen,
			KW_TABLE[i].llen) && (KW_TABLE[i].parent == look_cur ||
			opt_hop(KW_TABLE[i].parent, look_cur));
	end
	assign any_hit = |hit;

	// lowest entry wins if two forms collide
	always_comb begin
		hit_id = NODE_ROOT;
		for (int i = KW_N - 1; i >= 0; i--) begin
			if (hit[i]) begin
				hit_id = node_t'(i + 1);
			end
		end
	end

	// ----------------------------------------------------------------
	// parser state
	// ----------------------------------------------------------------
	always_comb begin
		logic do_done, do_err, do_pend;
		do_done = 1'b0;
		do_err = 1'b0;
		do_pend = 1'b0;
		st_nxt = st_r;
		cur_nxt = cur_r;
		base_nxt = base_r;
		kb_nxt = kb_r;
		kl_nxt = kl_r;
		suf_nxt = suf_r;
		sufon_nxt = sufon_r;
		query_nxt = query_r;
		common_nxt = common_r;
		pidx_nxt = pidx_r;
		cmd_nxt = cmd_r;
		par_nxt = par_r;
		cmdv_nxt = 1'b0;
		parv_nxt = 1'b0;
		pend_nxt = 1'b0;
		if (take) begin
			unique case (st_r)
				ST_START, ST_HDR: begin
					if (st_r == ST_START && (ws || nl || byte_data == CH_SEMI)) begin
						if (endl) begin
							base_nxt = NODE_ROOT;
						end
					end else if (st_r == ST_START && byte_data == CH_COLON && !eoi) begin
						cur_nxt = NODE_ROOT;
						st_nxt = ST_HDR;
					end else if (st_r == ST_START && byte_data == CH_STAR && !eoi) begin
						cur_nxt = NODE_COMMON;
						common_nxt = 1'b1;
						st_nxt = ST_HDR;
					end else if (name_bad || (!letter && !digit && !delim) ||
							byte_data == CH_COMMA) begin
						do_err = 1'b1;
					end else if (byte_data == CH_COLON && !eoi) begin
						if (!any_hit) begin
							do_err = 1'b1;
						end else begin
							cur_nxt = hit_id;
							kb_nxt = '0;
							kl_nxt = 4'h0;
							suf_nxt = 8'h00;
							sufon_nxt = 1'b0;
							st_nxt = ST_HDR;
						end
					end else if (delim || eoi) begin
						// header complete
						if (!any_hit) begin
							do_err = 1'b1;
						end else begin
							// a lone root word decodes like any node
							cmdv_nxt = 1'b1;
							cmd_nxt.func = hit_id;
							cmd_nxt.query = byte_data == CH_QUERY;
							cmd_nxt.common = common_r;
							cmd_nxt.suffix = sufon_v ? suf_v : SUFFIX_DEFAULT;
							query_nxt = byte_data == CH_QUERY;
							// remember path for the next command
							base_nxt = common_r ? base_r : look_cur;
							kb_nxt = '0;
							kl_nxt = 4'h0;
							suf_nxt = 8'h00;
							sufon_nxt = 1'b0;
							pidx_nxt = 4'h0;
							if (byte_data == CH_QUERY && !eoi) begin
								st_nxt = ST_AFTQ;
							end else if (ws && !endl) begin
								st_nxt = ST_GAP;
							end else begin
								do_done = 1'b1;
							end
						end
					end else begin
						kb_nxt = kb_v;
						kl_nxt = kl_v;
						suf_nxt = suf_v;
						sufon_nxt = sufon_v;
						cur_nxt = look_cur;
						st_nxt = ST_HDR;
					end
				end
				ST_AFTQ: begin
					if (byte_data == CH_SEMI || endl) begin
						do_done = 1'b1;
					end else if (ws) begin
						st_nxt = ST_GAP;
					end else begin
						do_err = 1'b1;
					end
				end
				ST_GAP, ST_PAR: begin
					if (!delim) begin
						// parameter text streams out byte by byte
						parv_nxt = 1'b1;
						par_nxt.data = byte_data;
						kb_nxt = kb_v;
						kl_nxt = kl_v;
						st_nxt = ST_PAR;
					end
					if (st_r == ST_GAP && (byte_data == CH_COMMA || byte_data == CH_QUERY)) begin
						do_err = 1'b1;
					end else if ((st_r == ST_PAR || !delim) &&
							(byte_data == CH_COMMA || byte_data == CH_SEMI || endl)) begin
						pend_nxt = 1'b1;
						par_nxt.idx = pidx_r;
						par_nxt.kind = PAR_RAW;
						if (query_r && kw_hit(kb_v, kl_v, SPC_MIN, SPC_SLEN, SPC_LLEN)) begin
							par_nxt.kind = PAR_MIN;
						end else if (query_r && kw_hit(kb_v, kl_v, SPC_MAX, SPC_SLEN, SPC_LLEN)) begin
							par_nxt.kind = PAR_MAX;
						end else if (query_r && kw_hit(kb_v, kl_v, SPC_DEF, SPC_SLEN, SPC_LLEN)) begin
							par_nxt.kind = PAR_DEF;
						end
						kb_nxt = '0;
						kl_nxt = 4'h0;
						if (byte_data == CH_COMMA && !eoi) begin
							pidx_nxt = 4'(pidx_r + 4'h1);
							st_nxt = ST_GAP;
						end else begin
							do_done = 1'b1;
						end
					end else if (byte_data == CH_SEMI || endl) begin
						do_done = 1'b1;
					end
				end
				ST_SKIP: begin
					// discard up to the next command
					if (byte_data == CH_SEMI || endl) begin
						st_nxt = ST_START;
						if (endl) begin
							base_nxt = NODE_ROOT;
						end
					end
				end
			endcase
			if (do_done || do_err) begin
				kb_nxt = '0;
				kl_nxt = 4'h0;
				suf_nxt = 8'h00;
				sufon_nxt = 1'b0;
				common_nxt = 1'b0;
				query_nxt = 1'b0;
				st_nxt = ST_START;
				if (endl) begin
					base_nxt = NODE_ROOT;
				end
			end
			if (do_err && !endl && byte_data != CH_SEMI) begin
				st_nxt = ST_SKIP;
			end
			// query asks the output path for data; a query ended by end-or-identify
			// on its question mark has not reached query_r yet
			do_pend = do_done && (query_r || ((st_r == ST_START || st_r == ST_HDR) &&
				byte_data == CH_QUERY));
		end
		done_nxt = take && do_done;
		err_nxt = take && do_err;
		// held until taken; a new request wins over the acknowledge
		resp_nxt = do_pend || (resp_r && !resp_ack);
	end

	// ----------------------------------------------------------------
	// checks on the parser outputs
	// ----------------------------------------------------------------
	// a response stays owed until the controller takes it
	sequence s_resp_wait;
		resp_r && !resp_ack;
	endsequence
	sequence s_query_end;
		done_r && cmd_r.query;
	endsequence
	property p_atn_quiet;
		atn |=> !cmdv_r && !parv_r && !pend_r && !done_r && !err_r;
	endproperty
	a_atn_quiet: assert property (p_atn_quiet) else $error("event after attention byte");
	property p_query_resp;
		done_r |-> resp_r == cmd_r.query;
	endproperty
	a_query_resp: assert property (p_query_resp) else $error("response flag wrong");
	property p_resp_cause;
		$rose(resp_r) |-> s_query_end;
	endproperty
	a_resp_cause: assert property (p_resp_cause) else $error("unsolicited response");
	property p_resp_hold;
		s_resp_wait |=> resp_r;
	endproperty
	a_resp_hold: assert property (p_resp_hold) else $error("response dropped early");
	property p_err_discard;
		err_r |-> !cmdv_r && !done_r;
	endproperty
	a_err_discard: assert property (p_err_discard) else $error("errored command reported");
	property p_line_root;
		take && endl |=> st_r == ST_START && base_r == NODE_ROOT;
	endproperty
	a_line_root: assert property (p_line_root) else $error("path kept past line end");

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!nrst) begin
			st_r <= ST_START;
			cur_r <= NODE_ROOT;
			base_r <= NODE_ROOT;
			kb_r <= '0;
			kl_r <= 4'h0;
			suf_r <= 8'h00;
			sufon_r <= 1'b0;
			query_r <= 1'b0;
			common_r <= 1'b0;
			pidx_r <= 4'h0;
			cmd_r <= '0;
			par_r <= '0;
			cmdv_r <= 1'b0;
			parv_r <= 1'b0;
			pend_r <= 1'b0;
			done_r <= 1'b0;
			err_r <= 1'b0;
			resp_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			cur_r <= cur_nxt;
			base_r <= base_nxt;
			kb_r <= kb_nxt;
			kl_r <= kl_nxt;
			suf_r <= suf_nxt;
			sufon_r <= sufon_nxt;
			query_r <= query_nxt;
			common_r <= common_nxt;
			pidx_r <= pidx_nxt;
			cmd_r <= cmd_nxt;
			par_r <= par_nxt;
			cmdv_r <= cmdv_nxt;
			parv_r <= parv_nxt;
			pend_r <= pend_nxt;
			done_r <= done_nxt;
			err_r <= err_nxt;
			resp_r <= resp_nxt;
		end
	end

	assign resp_req = resp_r;
	assign cmd_valid = cmdv_r;
	assign cmd = cmd_r;
	assign par_valid = parv_r;
	assign par_end = pend_r;
	assign par = par_r;
	assign done_valid = done_r;
	assign cmd_err = err_r;

endmodule // scpi_header_parser

// >>> testbench/host_ctrl_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// controller on the far side: sends message bytes, reads answers
// ----------------------------------------------------------------
module host_ctrl_model (
	input wire logic clk,
	output logic byte_valid,
	output logic [7:0] byte_data,
	output logic atn,
	output logic eoi,
	input wire logic byte_ready,
	input wire logic resp_req,
	output logic resp_ack
);
	initial begin
		byte_valid = 1'b0;
		byte_data = 8'hff;
		atn = 1'b0;
		eoi = 1'b0;
		resp_ack = 1'b0;
	end

	// answers are taken as soon as they are offered
	always @(negedge clk) begin
		resp_ack <= resp_req;
	end

	// one byte held until accepted; bounded so a stuck parser cannot hang us
	task automatic put(input logic [7:0] b, input logic last, input logic attn,
			output logic ok);
		int n;
		n = 0;
		ok = 1'b0;
		@(negedge clk);
		atn = attn;
		byte_valid = 1'b1;
		byte_data = b;
		eoi = last;
		while (!ok && n < 40) begin
			@(posedge clk);
			ok = (byte_ready === 1'b1);
			n++;
		end
	endtask

	// send a string byte by byte, end-or-identify on its last byte if asked
	task automatic send(input string s, input logic eoi_end, input logic attn,
			output int taken);
		logic ok;
		taken = 0;
		for (int i = 0; i < s.len(); i++) begin
			put(s[i], eoi_end && (i == s.len() - 1), attn, ok);
			taken += ok;
		end
		@(negedge clk);
		byte_valid = 1'b0;
		eoi = 1'b0;
		atn = 1'b0;
		// released data line must not look like the last byte
		byte_data = ~byte_data;
	endtask
endmodule // host_ctrl_model

// >>> testbench/scpi_header_parser_test.sv
`timescale 1ns/10ps
module scpi_header_parser_test
	import scpi_pkg::*;
;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic byte_valid, atn, eoi, byte_ready, resp_ack, resp_req;
	logic cmd_valid, par_valid, par_end, done_valid, cmd_err, resp_prev;
	logic [7:0] byte_data;
	cmd_s cmd;
	par_s par;
	cmd_s cq[$];
	par_s pq[$];
	int n_errors = 0;
	int n_compared = 0;
	int n_err, n_resp, n_done, n_pbytes;

	always #5 clk = ~clk;

	scpi_header_parser DUT (.clk(clk), .nrst(nrst), .byte_valid(byte_valid),
		.byte_data(byte_data), .atn(atn), .eoi(eoi), .byte_ready(byte_ready),
		.resp_ack(resp_ack), .resp_req(resp_req), .cmd_valid(cmd_valid), .cmd(cmd),
		.par_valid(par_valid), .par_end(par_end), .par(par), .done_valid(done_valid),
		.cmd_err(cmd_err));

	host_ctrl_model host (.clk(clk), .byte_valid(byte_valid), .byte_data(byte_data),
		.atn(atn), .eoi(eoi), .byte_ready(byte_ready), .resp_req(resp_req),
		.resp_ack(resp_ack));

	// ----------------------------------------------------------------
	// monitor: collect every event the parser emits
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		if (nrst === 1'b1) begin
			if (cmd_valid === 1'b1) cq.push_back(cmd);
			if (par_valid === 1'b1) n_pbytes++;
			if (par_end === 1'b1) pq.push_back(par);
			if (cmd_err === 1'b1) n_err++;
			if (done_valid === 1'b1) n_done++;
			if (resp_req === 1'b1 && resp_prev !== 1'b1) n_resp++;
		end
		resp_prev = resp_req;
	end

	// ----------------------------------------------------------------
	// shared helpers
	// ----------------------------------------------------------------
	task automatic summarize;
		$display("errors=%0d compared=%0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// send one line and wait, bounded, for a first completion or error to be reported
	task automatic run(input string s, input logic use_eoi);
		int taken;
		int n;
		cq.delete();
		pq.delete();
		n_err = 0;
		n_resp = 0;
		n_done = 0;
		n_pbytes = 0;
		host.send(s, use_eoi, 1'b0, taken);
		check(taken, s.len());
		n = 0;
		// a discarded command ends in an error report instead of a completion
		while ((n_done + n_err) < 1 && n < 100) begin
			@(posedge clk);
			n++;
		end
		if ((n_done + n_err) < 1) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, n_done + n_err, 1);
			summarize();
		end
		repeat (4) @(posedge clk);
	endtask

	task automatic cmd_is(input int i, input node_t f, input logic q, input logic c);
		check({cq[i].func, cq[i].query, cq[i].common}, {f, q, c});
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic sc_query;
		string s[3] = '{"sense:freq:stop? MAX\n", "SENS:FREQ:STOP? minimum\n",
			"Sense:Frequency:Stop? DEF\n"};
		par_kind_e k[3] = '{PAR_MAX, PAR_MIN, PAR_DEF};
		for (int i = 0; i < 3; i++) begin
			run(s[i], 1'b0);
			check(cq.size(), 1);
			cmd_is(0, 5'h05, 1'b1, 1'b0);
			check(pq.size(), 1);
			check(pq[0].kind, k[i]);
			check(n_resp, 1);
		end
	endtask

	task automatic sc_path;
		run("SENS:FREQ:STAR 1;STOP 2;:INP:ATT 10\n", 1'b0);
		check(cq.size(), 3);
		cmd_is(0, 5'h04, 1'b0, 1'b0);
		cmd_is(1, 5'h05, 1'b0, 1'b0);
		cmd_is(2, 5'h0c, 1'b0, 1'b0);
		check(n_resp, 0);
		check(n_err, 0);
		run("STOP 1\n", 1'b0);
		check(cq.size(), 0);
		check(n_err > 0, 1);
	endtask

	task automatic sc_opt;
		run("BAND:AUTO ON\n", 1'b0);
		cmd_is(0, 5'h0a, 1'b0, 1'b0);
		run("SENS:BAND:RESOLUTION:AUTO ON\n", 1'b0);
		cmd_is(0, 5'h0a, 1'b0, 1'b0);
		run("INP\n", 1'b0);
		cmd_is(0, 5'h0b, 1'b0, 1'b0);
		run("INP:ATT3 5\n", 1'b0);
		cmd_is(0, 5'h0c, 1'b0, 1'b0);
		check(cq[0].suffix, 8'h03);
	endtask

	task automatic sc_level;
		run("SOUR:FM:POL NORM\n", 1'b0);
		cmd_is(0, 5'h10, 1'b0, 1'b0);
		run("sour:fm:ext:pol NORM\n", 1'b0);
		cmd_is(0, 5'h12, 1'b0, 1'b0);
	endtask

	task automatic sc_common;
		run("*ESE 1,2,3\n", 1'b0);
		cmd_is(0, 5'h14, 1'b0, 1'b1);
		check(pq.size(), 3);
		check(n_pbytes, 3);
		check(pq[1].data, 8'h32);
		check(pq[2].idx, 4'h2);
		run("*rst\n", 1'b0);
		cmd_is(0, 5'h13, 1'b0, 1'b1);
		check(n_resp, 0);
		run("*IDN?\n", 1'b0);
		cmd_is(0, 5'h17, 1'b1, 1'b1);
		check(n_resp, 1);
	endtask

	task automatic sc_bad;
		run("SENS:FREQU 1\n", 1'b0);
		check(cq.size(), 0);
		check(n_err > 0, 1);
		run("SENS:FR 1\n", 1'b0);
		check(cq.size(), 0);
	endtask

	// vertical tab separates; line ended by end-or-identify alone
	task automatic sc_ws_eoi;
		run("SENS:FREQ:CENT\v5;SPAN\t7", 1'b1);
		check(cq.size(), 2);
		cmd_is(0, 5'h03, 1'b0, 1'b0);
		check(cq[0].suffix, SUFFIX_DEFAULT);
		cmd_is(1, 5'h06, 1'b0, 1'b0);
		check(pq.size(), 2);
	endtask

	// bytes under attention must not form a command
	task automatic sc_atn;
		int taken;
		cq.delete();
		n_done = 0;
		host.send("*RST\n", 1'b0, 1'b1, taken);
		repeat (20) @(posedge clk);
		check(cq.size(), 0);
		check(n_done, 0);
	endtask

	// ----------------------------------------------------------------
	// main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		repeat (10) @(negedge clk);
		nrst = 1'b1;
		repeat (2) @(negedge clk);
		sc_query();
		sc_path();
		sc_opt();
		sc_level();
		sc_common();
		sc_bad();
		sc_ws_eoi();
		sc_atn();
		summarize();
	end

	initial begin
		#500000;
		n_errors++;
		summarize();
	end
endmodule // scpi_header_parser_test
